// ===== dfc_pkg.sv
// dfc_pkg: constants for the display function 1 identification, command and status bank.
// assumes a dword-wide configuration port; byte offsets are those of the configuration header.
package dfc_pkg;

  // byte offsets in configuration space
  localparam logic [7:0]  DFC_OFS_DEVICE_IDENT  = 8'h02;
  localparam logic [7:0]  DFC_OFS_CMD_CONTROL   = 8'h04;
  localparam logic [7:0]  DFC_OFS_STATUS_REPORT = 8'h06;

  // dword index of each register (byte offset divided by four)
  localparam logic [5:0]  DFC_DW_IDENT  = DFC_OFS_DEVICE_IDENT[7:2];
  localparam logic [5:0]  DFC_DW_CMDSTS = DFC_OFS_CMD_CONTROL[7:2];

  // identifier value: arbitrary, differs from the function 0 identifier
  localparam logic [15:0] DFC_DEVICE_IDENT_NUMBER = 16'h5A3C;

  // command register layout
  localparam logic [15:0] DFC_CMD_RESET    = 16'h0000;
  localparam int          DFC_CMD_IO_BIT   = 0;
  localparam int          DFC_CMD_MEM_BIT  = 1;
  localparam int          DFC_CMD_BME_BIT  = 2;
  localparam int          DFC_CMD_RW_WIDTH = 3;

  // status register: constant pattern, bit 7 and bit 4 set
  localparam logic [15:0] DFC_STATUS_VALUE = 16'h0090;

  localparam logic [31:0] DFC_ZERO_WORD    = 32'h0000_0000;

endpackage

// ===== dfc_cmd_reg.sv
// dfc_cmd_reg: the three writable command bits of function 1.
// assumes write strobe and byte enable are already decoded for the command dword.
`timescale 1ns/1ps
`default_nettype none

module dfc_cmd_reg
  import dfc_pkg::*;
(
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        reset,
  // write side
  input  wire logic                        wr_en,
  input  wire logic                        wr_lane0,
  input  wire logic [7:0]                  wr_byte,
  // held command bits
  output logic      [DFC_CMD_RW_WIDTH-1:0] cmd_bits
);

  typedef struct packed {
    logic [DFC_CMD_RW_WIDTH-1:0] cmd;
  } dfc_cmd_state_t;

  dfc_cmd_state_t state_ff;
  dfc_cmd_state_t nxt_state;

  // only the low byte lane carries writable bits; upper lane writes fall away
  always_comb begin
    nxt_state = state_ff;
    if (wr_en && wr_lane0) begin
      nxt_state.cmd = wr_byte[DFC_CMD_RW_WIDTH-1:0];
    end
  end

  // reset clears all enables so the function starts silent
  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff.cmd <= DFC_CMD_RESET[DFC_CMD_RW_WIDTH-1:0];
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign cmd_bits = state_ff.cmd;

endmodule
`default_nettype wire

// ===== dfc_cfg_bank.sv
// dfc_cfg_bank: identification, command and status registers of display function 1,
// with the enables gating memory, io and bus-master activity of the function.
// assumes cfg_valid is already decoded for bus 0, device 2, function 1 by the host.
`timescale 1ns/1ps
`default_nettype none

module dfc_cfg_bank
  import dfc_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // configuration request
  input  wire logic        cfg_valid,
  input  wire logic        cfg_write,
  input  wire logic [5:0]  cfg_dword_addr,
  input  wire logic [3:0]  cfg_byte_en,
  input  wire logic [31:0] cfg_wdata,
  // configuration answer
  output logic             cfg_done,
  output logic      [31:0] cfg_rdata,
  // decode hits from the function's address decoders
  input  wire logic        mem_access_hit,
  input  wire logic        io_access_hit,
  // mastering request from the display engine
  input  wire logic        master_request,
  // gated results
  output logic             mem_claim,
  output logic             io_claim,
  output logic             master_grant,
  output logic             system_error,
  // enable levels for the rest of the function
  output logic             bus_master_enable,
  output logic             memory_space_enable,
  output logic             io_space_enable
);

  typedef struct packed {
    logic        done;
    logic [31:0] rdata;
    logic        mem_claim;
    logic        io_claim;
    logic        grant;
    logic        serr;
  } dfc_bank_state_t;

  dfc_bank_state_t                   state_ff;
  dfc_bank_state_t                   nxt_state;
  logic [DFC_CMD_RW_WIDTH-1:0]       cmd_bits;
  logic                              cmd_wr_en;
  logic [15:0]                       cmd_word;

  // the command dword is the only writable target
  assign cmd_wr_en = cfg_valid && cfg_write && (cfg_dword_addr == DFC_DW_CMDSTS);

  dfc_cmd_reg u_cmd (
    .clk      (clk),
    .reset    (reset),
    .wr_en    (cmd_wr_en),
    .wr_lane0 (cfg_byte_en[0]),
    .wr_byte  (cfg_wdata[7:0]),
    .cmd_bits (cmd_bits)
  );

  // hardwired command bits 15:3 are zero padding around the writable field
  assign cmd_word = {13'h0000, cmd_bits};

  // next-state: answer every request one cycle later, gate traffic by enables
  always_comb begin
    nxt_state       = state_ff;
    nxt_state.done  = cfg_valid;
    nxt_state.rdata = DFC_ZERO_WORD;
    if (cfg_valid && !cfg_write) begin
      case (cfg_dword_addr)
        DFC_DW_IDENT: begin
          // low half (vendor) is outside this bank and reads zero here
          nxt_state.rdata = {DFC_DEVICE_IDENT_NUMBER, 16'h0000};
        end
        DFC_DW_CMDSTS: begin
          nxt_state.rdata = {DFC_STATUS_VALUE, cmd_word};
        end
        default: begin
          nxt_state.rdata = DFC_ZERO_WORD;
        end
      endcase
    end
    nxt_state.mem_claim = mem_access_hit && cmd_bits[DFC_CMD_MEM_BIT];
    nxt_state.io_claim  = io_access_hit && cmd_bits[DFC_CMD_IO_BIT];
    nxt_state.grant     = master_request && cmd_bits[DFC_CMD_BME_BIT];
    // parity trouble is never escalated, so system error stays low for good
    nxt_state.serr      = 1'b0;
  end

  // single state register for the bank
  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff.done      <= 1'b0;
      state_ff.rdata     <= DFC_ZERO_WORD;
      state_ff.mem_claim <= 1'b0;
      state_ff.io_claim  <= 1'b0;
      state_ff.grant     <= 1'b0;
      state_ff.serr      <= 1'b0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // outputs straight from flops (the enables come from the command flops)
  assign cfg_done            = state_ff.done;
  assign cfg_rdata           = state_ff.rdata;
  assign mem_claim           = state_ff.mem_claim;
  assign io_claim            = state_ff.io_claim;
  assign master_grant        = state_ff.grant;
  assign system_error        = state_ff.serr;
  assign bus_master_enable   = cmd_bits[DFC_CMD_BME_BIT];
  assign memory_space_enable = cmd_bits[DFC_CMD_MEM_BIT];
  assign io_space_enable     = cmd_bits[DFC_CMD_IO_BIT];

  // checks on the bank behaviour
  default clocking dfc_cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_cmd_write_lane0;
    cfg_valid && cfg_write && cfg_dword_addr == DFC_DW_CMDSTS && cfg_byte_en[0];
  endsequence

  sequence s_cmdsts_read;
    cfg_valid && !cfg_write && cfg_dword_addr == DFC_DW_CMDSTS;
  endsequence

  sequence s_cfg_write_any;
    cfg_valid && cfg_write;
  endsequence

  sequence s_discarded_write;
    cfg_valid && cfg_write && (cfg_dword_addr != DFC_DW_CMDSTS || !cfg_byte_en[0]);
  endsequence

  a_cmd_write_lands: assert property (
    s_cmd_write_lane0 |=> {bus_master_enable, memory_space_enable, io_space_enable}
                          == $past(cfg_wdata[2:0]))
    else $error("command write did not land in the enable bits");

  a_cmd_holds_idle: assert property (
    !(cfg_valid && cfg_write) |=> $stable({bus_master_enable, memory_space_enable,
                                           io_space_enable}))
    else $error("command bits changed without a write");

  a_status_const_read: assert property (
    s_cmdsts_read |=> cfg_done && cfg_rdata[31:16] == DFC_STATUS_VALUE)
    else $error("status did not read 0090h");

  a_cmd_fixed_zero: assert property (
    s_cmdsts_read |=> cfg_rdata[15:3] == 13'h0000)
    else $error("hardwired command bits read nonzero");

  a_cmd_read_match: assert property (
    s_cmdsts_read |=> cfg_rdata[2:0] == $past({bus_master_enable, memory_space_enable,
                                               io_space_enable}))
    else $error("command read does not show the enables");

  a_ident_read: assert property (
    cfg_valid && !cfg_write && cfg_dword_addr == DFC_DW_IDENT
      |=> cfg_done && cfg_rdata[31:16] == DFC_DEVICE_IDENT_NUMBER)
    else $error("identifier read wrong");

  a_master_gated: assert property (
    master_grant |-> $past(master_request) && $past(bus_master_enable))
    else $error("mastering granted while disabled");

  a_mem_gated: assert property (
    mem_access_hit && !memory_space_enable |=> !mem_claim)
    else $error("memory access claimed while disabled");

  a_io_gated: assert property (
    io_access_hit && io_space_enable |=> io_claim)
    else $error("enabled io access not claimed");

  a_no_sys_error: assert property (
    !system_error [*2])
    else $error("system error asserted");

  a_done_one_cycle: assert property (
    !cfg_valid |=> !cfg_done)
    else $error("answer without a request");

  // config answers: every write completes with an empty answer
  a_write_completes: assert property (
    s_cfg_write_any |=> cfg_done && cfg_rdata == DFC_ZERO_WORD)
    else $error("write did not complete with a zero answer");

  a_write_discarded: assert property (
    s_discarded_write |=> $stable({bus_master_enable, memory_space_enable,
                                   io_space_enable}))
    else $error("discarded write changed the enables");

  // traffic gating: the other direction of each enable (pass for master and memory, block for io)
  a_master_passes: assert property (
    master_request && bus_master_enable |=> master_grant)
    else $error("enabled mastering request not granted");

  a_mem_passes: assert property (
    mem_access_hit && memory_space_enable |=> mem_claim)
    else $error("enabled memory access not claimed");

  a_io_blocked: assert property (
    !io_space_enable |=> !io_claim)
    else $error("io access claimed while disabled");

endmodule
`default_nettype wire

// ===== dfc_host_model.sv
// dfc_host_model: configuration host issuing single-cycle requests to function 1.
// assumes the bench clock; requests change on the falling edge only.
`timescale 1ns/1ps
`default_nettype none

module dfc_host_model (
  // clock
  input  wire logic        clk,
  // configuration request
  output logic             cfg_valid,
  output logic             cfg_write,
  output logic      [5:0]  cfg_dword_addr,
  output logic      [3:0]  cfg_byte_en,
  output logic      [31:0] cfg_wdata
);
  // idle bus at time zero
  initial begin
    cfg_valid = 1'b0;
    cfg_write = 1'b0;
    cfg_dword_addr = 6'h00;
    cfg_byte_en = 4'h0;
    cfg_wdata = 32'h0000_0000;
  end

  // one request per call; calls in a row give back-to-back requests
  task automatic op(input logic wr, input logic [5:0] a, input logic [3:0] be,
                    input logic [31:0] d);
    @(negedge clk);
    cfg_valid = 1'b1;
    cfg_write = wr;
    cfg_dword_addr = a;
    cfg_byte_en = be;
    cfg_wdata = d;
  endtask

  // released lines show the inverse, so a stale copy is never mistaken for data
  task automatic idle();
    @(negedge clk);
    cfg_valid = 1'b0;
    cfg_write = ~cfg_write;
    cfg_dword_addr = ~cfg_dword_addr;
    cfg_byte_en = ~cfg_byte_en;
    cfg_wdata = ~cfg_wdata;
  endtask
endmodule

`default_nettype wire

// ===== display_fn1_pci_cmd_status_bench.sv
// display_fn1_pci_cmd_status_bench: self-checking bench for the function 1 bank.
// assumes dfc_pkg and dfc_host_model; a reference model is compared every cycle.
`timescale 1ns/1ps
`default_nettype none

module display_fn1_pci_cmd_status_bench;
  import dfc_pkg::*;
  logic        clk, reset, cfg_valid, cfg_write, cfg_done, mem_access_hit, io_access_hit;
  logic        master_request, mem_claim, io_claim, master_grant, system_error;
  logic        bus_master_enable, memory_space_enable, io_space_enable;
  logic [5:0]  cfg_dword_addr;
  logic [3:0]  cfg_byte_en;
  logic [31:0] cfg_wdata, cfg_rdata, m_rd = 32'h0000_0000;
  logic [31:0] rnd = 32'h1f25_d32f;
  logic [31:0] rnd_hit = 32'h1f25_d32f;
  logic [2:0]  m_cmd = 3'h0, m_gate = 3'h0;
  logic        m_done = 1'b0;
  int          errors = 0, checks_done = 0, cycles = 0;

  dfc_host_model host (.clk(clk), .cfg_valid(cfg_valid), .cfg_write(cfg_write),
    .cfg_dword_addr(cfg_dword_addr), .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata));

  dfc_cfg_bank DUT (.clk(clk), .reset(reset), .cfg_valid(cfg_valid), .cfg_write(cfg_write),
    .cfg_dword_addr(cfg_dword_addr), .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata),
    .cfg_done(cfg_done), .cfg_rdata(cfg_rdata), .mem_access_hit(mem_access_hit),
    .io_access_hit(io_access_hit), .master_request(master_request), .mem_claim(mem_claim),
    .io_claim(io_claim), .master_grant(master_grant), .system_error(system_error),
    .bus_master_enable(bus_master_enable), .memory_space_enable(memory_space_enable),
    .io_space_enable(io_space_enable));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // reference model: only lane 0 of the command dword holds state
  always @(posedge clk) begin
    m_done <= cfg_valid && !reset;
    m_gate <= reset ? 3'h0 : {master_request & m_cmd[2], mem_access_hit & m_cmd[1],
                              io_access_hit & m_cmd[0]};
    m_rd <= (reset || !cfg_valid || cfg_write) ? 32'h0000_0000 :
            (cfg_dword_addr == 6'h00) ? {DFC_DEVICE_IDENT_NUMBER, 16'h0000} :
            (cfg_dword_addr == 6'h01) ? {16'h0090, 13'h0000, m_cmd} : 32'h0000_0000;
    if (reset)
      m_cmd <= 3'h0;
    else if (cfg_valid && cfg_write && cfg_dword_addr == 6'h01 && cfg_byte_en[0])
      m_cmd <= cfg_wdata[2:0];
  end

  task automatic chk_cfg(input logic d, input logic [31:0] rd);
    checks_done++;
    if (d !== m_done || (m_done && rd !== m_rd)) begin
      errors++;
      $display("[FAIL] %0t answer %b %h expected %b %h", $time, d, rd, m_done, m_rd);
    end
  endtask

  task automatic chk_gate(input logic [6:0] g);
    checks_done++;
    if (g !== {m_gate, 1'b0, m_cmd}) begin
      errors++;
      $display("[FAIL] %0t gating %b expected %b", $time, g, {m_gate, 1'b0, m_cmd});
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // every falling edge after the first: compare, then drive fresh random traffic hits
  always @(negedge clk) begin
    cycles++;
    if (cycles > 1) begin
      chk_cfg(cfg_done,
              cfg_rdata);
      chk_gate({master_grant, mem_claim, io_claim, system_error, bus_master_enable,
                memory_space_enable, io_space_enable});
    end
    // own generator, so the request stream is not raced by this process
    rnd_hit = lfsr(rnd_hit);
    {master_request, mem_access_hit, io_access_hit} = rnd_hit[2:0];
    if (cycles > 2000) begin
      errors++;
      print_verdict();
    end
  end

  initial begin
    reset = 1'b1;
    {master_request, mem_access_hit, io_access_hit} = 3'h0;
    repeat (10) @(negedge clk);
    reset = 1'b0;
    // fixed fields, lane masking, writes to read-only dwords, unmapped reads
    host.op(1'b0, 6'h00, 4'hf, 32'h0000_0000);
    host.op(1'b0, 6'h01, 4'hf, 32'h0000_0000);
    host.op(1'b1, 6'h01, 4'hf, 32'hffff_ffff);
    host.op(1'b0, 6'h01, 4'hf, 32'h0000_0000);
    host.op(1'b1, 6'h01, 4'he, 32'h0000_0000);
    host.op(1'b1, 6'h00, 4'hf, 32'hffff_ffff);
    host.op(1'b0, 6'h00, 4'hf, 32'h0000_0000);
    host.op(1'b0, 6'h01, 4'hf, 32'h0000_0000);
    host.op(1'b0, 6'h3f, 4'hf, 32'h0000_0000);
    host.idle();
    $display("test fixed fields done");
    // random back-to-back mix of reads and writes
    repeat (300) begin
      rnd = lfsr(rnd);
      host.op(rnd[0], rnd[3] ? 6'h3f : {4'h0, rnd[2:1]}, rnd[7:4], lfsr(rnd));
    end
    host.idle();
    $display("test random traffic done");
    // reset in mid-run clears the enables
    host.op(1'b1, 6'h01, 4'h1, 32'h0000_0007);
    host.idle();
    reset = 1'b1;
    @(negedge clk);
    reset = 1'b0;
    host.op(1'b0, 6'h01, 4'hf, 32'h0000_0000);
    host.idle();
    repeat (3) @(negedge clk);
    $display("test second reset done");
    print_verdict();
  end
endmodule

`default_nettype wire
